/* File: rtl/pgs_regs.svh */
`ifndef PGS_REGS_SVH
`define PGS_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PGS_OFF_PIN_CTRL     8'h80
`define PGS_OFF_GEN_PIN      8'h81
`define PGS_OFF_PAT0         8'h90
`define PGS_OFF_PAT1         8'h91
`define PGS_OFF_PAT2         8'h92
`define PGS_OFF_PAT3         8'h93

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PGS_RST_PIN_CTRL     8'h01
`define PGS_RST_GEN_PIN      8'hFC
`define PGS_RST_PAT          8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PGS_PC_MODE_BIT      0
`define PGS_PC_DIR_BIT       1
`define PGS_PC_DATA_BIT      2
`define PGS_PC_DUTY_LSB      3
`define PGS_PC_RATE_LSB      6
`define PGS_GP_DIR_BIT       0
`define PGS_GP_DATA_BIT      1
`define PGS_GP_ONES          6'h3F
`define PGS_MAIN_EN_BIT      1
`define PGS_SUB_EN_BIT       2

// ----------------------------------------
// Timing (ns), counts at 5 ns clock
// ----------------------------------------
`define PGS_CLK_NS           5
`define PGS_T0_NS            1600
`define PGS_T1_NS            26000000
`define PGS_T2_NS            52000000
`define PGS_T3_NS            105000000
`define PGS_CYC(t)           ((t) / `PGS_CLK_NS)
`define PGS_PAT_BITS         32

`endif

/* File: rtl/pgs_pkg.sv */
package pgs_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgs_req_s;

    typedef struct packed {
        logic [1:0] rate;
        logic [2:0] duty;
        logic       gdata;
        logic       gdir;
        logic       mode;
    } pgs_pin_ctrl_s;

    typedef enum logic [2:0] {
        PGS_IDLE = 3'b001,
        PGS_SEND = 3'b010,
        PGS_DEAD = 3'b100
    } pgs_state_e;

endpackage

/* File: rtl/pgs_bit_timer.sv */
`timescale 1ns/100ps
`include "pgs_regs.svh"

module pgs_bit_timer
    import pgs_pkg::*;
#(
    parameter int unsigned CNT0 = `PGS_CYC(`PGS_T0_NS),
    parameter int unsigned CNT1 = `PGS_CYC(`PGS_T1_NS),
    parameter int unsigned CNT2 = `PGS_CYC(`PGS_T2_NS),
    parameter int unsigned CNT3 = `PGS_CYC(`PGS_T3_NS)
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       restart,
    input  wire logic [1:0] rate,
    output logic            tick
);

    // Counts must be nonzero and CNT3 must fit the 27-bit counter
    if (CNT0 < 1 || CNT1 < 1 || CNT2 < 1 || CNT3 < 1 || CNT3 >= 2**27) begin : g_bad_cnt
        $error("pgs_bit_timer: unsupported bit time count");
    end

    logic [26:0] count;
    logic [26:0] limit;

    always_comb begin
        case (rate)
            2'b00:   limit = 27'(CNT0 - 1);
            2'b01:   limit = 27'(CNT1 - 1);
            2'b10:   limit = 27'(CNT2 - 1);
            default: limit = 27'(CNT3 - 1);
        endcase
    end

    // Bit time from clock count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 27'h0000000;
            tick  <= 1'b0;
        end else if (restart) begin
            count <= 27'h0000000;
            tick  <= 1'b0;
        end else if (count >= limit) begin
            count <= 27'h0000000;
            tick  <= 1'b1;
        end else begin
            count <= count + 27'h0000001;
            tick  <= 1'b0;
        end
    end

endmodule // pgs_bit_timer

/* File: rtl/pgs_top.sv */
`timescale 1ns/100ps
`include "pgs_regs.svh"

module pgs_top
    import pgs_pkg::*;
#(
    parameter int unsigned CNT0 = `PGS_CYC(`PGS_T0_NS),
    parameter int unsigned CNT1 = `PGS_CYC(`PGS_T1_NS),
    parameter int unsigned CNT2 = `PGS_CYC(`PGS_T2_NS),
    parameter int unsigned CNT3 = `PGS_CYC(`PGS_T3_NS)
) (
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    // Register port
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // Multi-function pin
    input  wire logic       MFP_IN,
    output logic            MFP_OUT,
    output logic            MFP_OE,
    // Hardware enable seen on pin
    output logic            HW_ENABLE,
    // Dedicated general pin
    input  wire logic       GPIN_IN,
    output logic            GPIN_OUT,
    output logic            GPIN_OE,
    // Current sink enables
    output logic            MAIN_SINK_ENABLE,
    output logic            SECONDARY_SINK_ENABLE
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    pgs_req_s      req;
    pgs_pin_ctrl_s pin_ctrl;
    logic [7:0]    pattern_byte [4];
    logic [1:0]    gen_pin;
    logic [31:0]   pattern;
    logic          ctrl_wr;

    assign req     = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};
    assign ctrl_wr = req.wr && (req.addr == `PGS_OFF_PIN_CTRL);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_ctrl <= pgs_pin_ctrl_s'(`PGS_RST_PIN_CTRL);
        end else if (ctrl_wr) begin
            pin_ctrl <= pgs_pin_ctrl_s'(req.wdata);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pat
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    pattern_byte[gi] <= `PGS_RST_PAT;
                end else if (req.wr && req.addr == 8'(`PGS_OFF_PAT0 + gi)) begin
                    pattern_byte[gi] <= req.wdata;
                end
            end
            assign pattern[gi*8 +: 8] = pattern_byte[gi];
        end
    endgenerate

    // General register: bit 1 data, bit 0 direction; ones above read back
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            gen_pin <= 2'(`PGS_RST_GEN_PIN);
        end else if (req.wr && req.addr == `PGS_OFF_GEN_PIN) begin
            gen_pin <= req.wdata[1:0];
        end
    end

    // ----------------------------------------
    // Sink enables
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            MAIN_SINK_ENABLE      <= 1'b0;
            SECONDARY_SINK_ENABLE <= 1'b0;
        end else if (req.wr && req.addr == `PGS_OFF_GEN_PIN) begin
            MAIN_SINK_ENABLE      <= req.wdata[`PGS_MAIN_EN_BIT];
            SECONDARY_SINK_ENABLE <= req.wdata[`PGS_SUB_EN_BIT];
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `PGS_OFF_PIN_CTRL: REG_RDATA <= {pin_ctrl.rate, pin_ctrl.duty,
                                    (pin_ctrl.gdir ? MFP_IN : pin_ctrl.gdata),
                                    pin_ctrl.gdir, pin_ctrl.mode};
                `PGS_OFF_GEN_PIN:  REG_RDATA <= {`PGS_GP_ONES,
                                    (gen_pin[0] ? gen_pin[1] : GPIN_IN), gen_pin[0]};
                `PGS_OFF_PAT0:     REG_RDATA <= pattern_byte[0];
                `PGS_OFF_PAT1:     REG_RDATA <= pattern_byte[1];
                `PGS_OFF_PAT2:     REG_RDATA <= pattern_byte[2];
                `PGS_OFF_PAT3:     REG_RDATA <= pattern_byte[3];
                default:           REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Pattern sequencer
    // ----------------------------------------
    logic       tick;
    logic       pat_mode;
    logic [4:0] bit_idx;
    logic [1:0] dead_pat;
    logic [1:0] dead_need;
    pgs_state_e state;

    assign pat_mode = pin_ctrl.mode && (pin_ctrl.duty != 3'b000);

    // Duty 1/n -> n-1 dead patterns; codes 5-7 run full duty, code 0 disables pattern mode
    always_comb begin
        case (pin_ctrl.duty)
            3'b010:  dead_need = 2'd1;
            3'b011:  dead_need = 2'd2;
            3'b100:  dead_need = 2'd3;
            default: dead_need = 2'd0;
        endcase
    end

    pgs_bit_timer #(
        .CNT0 (CNT0),
        .CNT1 (CNT1),
        .CNT2 (CNT2),
        .CNT3 (CNT3)
    ) u_timer (
        .clk     (MCLK),
        .rst_n   (RST_N),
        .restart (ctrl_wr || !pat_mode),
        .rate    (pin_ctrl.rate),
        .tick    (tick)
    );

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state    <= PGS_IDLE;
            bit_idx  <= 5'd0;
            dead_pat <= 2'd0;
        end else if (ctrl_wr || !pat_mode) begin
            state    <= PGS_IDLE;
            bit_idx  <= 5'd0;
            dead_pat <= 2'd0;
        end else begin
            case (state)
                PGS_IDLE: state <= PGS_SEND;
                PGS_SEND: begin
                    if (tick) begin
                        bit_idx <= bit_idx + 5'd1;
                        if (bit_idx == 5'd31 && dead_need != 2'd0) begin
                            state    <= PGS_DEAD;
                            dead_pat <= 2'd0;
                        end
                    end
                end
                PGS_DEAD: begin
                    if (tick) begin
                        bit_idx <= bit_idx + 5'd1;
                        if (bit_idx == 5'd31) begin
                            if (dead_pat + 2'd1 >= dead_need) begin
                                state <= PGS_SEND;
                            end
                            dead_pat <= dead_pat + 2'd1;
                        end
                    end
                end
                default: state <= PGS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            MFP_OUT   <= 1'b0;
            MFP_OE    <= 1'b0;
            HW_ENABLE <= 1'b0;
        end else begin
            HW_ENABLE <= !pin_ctrl.mode && MFP_IN;
            if (!pin_ctrl.mode) begin
                MFP_OUT <= 1'b0;
                MFP_OE  <= 1'b0;
            end else if (pat_mode) begin
                MFP_OUT <= 1'b0;
                MFP_OE  <= (state == PGS_SEND) && pattern[bit_idx];
            end else if (!pin_ctrl.gdir) begin
                MFP_OUT <= pin_ctrl.gdata;
                MFP_OE  <= 1'b1;
            end else begin
                MFP_OUT <= 1'b0;
                MFP_OE  <= 1'b0;
            end
        end
    end

    // Dedicated general pin: direction 1 drives bit 1
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            GPIN_OUT <= 1'b0;
            GPIN_OE  <= 1'b0;
        end else begin
            GPIN_OUT <= gen_pin[1];
            GPIN_OE  <= gen_pin[0];
        end
    end

endmodule // pgs_top

/* File: bench/pgs_pin_model.sv */
`timescale 1ns/100ps
module pgs_pin_model (
    // Device side
    input  wire logic drv_out,
    input  wire logic drv_oe,
    // Scenario control
    input  wire logic pull_low,
    // Wire level
    output logic      pin_level
);
    // Released line rests at the pull-up unless pulled low outside
    assign pin_level = drv_oe ? drv_out : !pull_low;
endmodule // pgs_pin_model

/* File: bench/pgs_top_chk.sv */
`timescale 1ns/100ps
module pgs_top_chk
    import pgs_pkg::*;
(
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       MFP_IN,
    input wire logic       MFP_OUT,
    input wire logic       MFP_OE,
    input wire logic       HW_ENABLE,
    input wire logic       GPIN_OE,
    input wire logic       MAIN_SINK_ENABLE,
    input wire logic       SECONDARY_SINK_ENABLE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] ctrl;
    logic [1:0] quiet;
    wire        wr_ctrl = REG_WR && REG_ADDR == 8'h80;
    wire        wr_gen  = REG_WR && REG_ADDR == 8'h81;
    wire        settled = quiet == 2'h3;
    // Shadow of the pin control register
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) ctrl <= 8'h01;
        else if (wr_ctrl) ctrl <= REG_WDATA;
    end
    // Cycles since the last control write
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) quiet <= 2'h0;
        else if (wr_ctrl) quiet <= 2'h0;
        else if (!settled) quiet <= quiet + 2'h1;
    end
    sequence pat_start_s;
        wr_ctrl && REG_WDATA[0] && REG_WDATA[5:3] != 3'h0;
    endsequence
    sequence gap_s;
        ##2 !MFP_OE;
    endsequence
    sink_main_a: assert property (wr_gen |=> MAIN_SINK_ENABLE == $past(REG_WDATA[1]))
        else $error("main sink enable wrong");
    sink_sec_a: assert property (wr_gen |=> SECONDARY_SINK_ENABLE == $past(REG_WDATA[2]))
        else $error("secondary sink enable wrong");
    gen_dir_a: assert property (wr_gen |=> ##1 GPIN_OE == $past(REG_WDATA[0], 2))
        else $error("general pin direction wrong");
    gen_ones_a: assert property (REG_RD && REG_ADDR == 8'h81 |=> REG_RDATA[7:2] == 6'h3F)
        else $error("general register top bits not ones");
    hw_off_a: assert property (ctrl[0] && settled |-> !HW_ENABLE)
        else $error("hardware enable seen outside enable mode");
    hw_on_a: assert property (!ctrl[0] && settled |=> HW_ENABLE == $past(MFP_IN))
        else $error("hardware enable does not follow pin");
    pin_idle_a: assert property ((!ctrl[0] || ctrl[5:1] == 5'h01) && settled |-> !MFP_OE)
        else $error("pin driven while idle");
    open_drain_a: assert property (ctrl[0] && ctrl[5:3] != 3'h0 && settled |-> !(MFP_OE && MFP_OUT))
        else $error("pattern pin driven high");
    gpio_out_a: assert property (ctrl[2:0] != 3'h7 && ctrl[1:0] == 2'h1 && ctrl[5:3] == 3'h0 && settled
        |-> MFP_OE && MFP_OUT == ctrl[2])
        else $error("general output level wrong");
    restart_gap_a: assert property (pat_start_s |-> gap_s)
        else $error("pattern not restarted");
endmodule // pgs_top_chk
bind pgs_top pgs_top_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MFP_IN(MFP_IN),
    .MFP_OUT(MFP_OUT), .MFP_OE(MFP_OE), .HW_ENABLE(HW_ENABLE), .GPIN_OE(GPIN_OE),
    .MAIN_SINK_ENABLE(MAIN_SINK_ENABLE), .SECONDARY_SINK_ENABLE(SECONDARY_SINK_ENABLE));

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
    localparam int CNT [4] = '{4, 8, 12, 16};
    logic       MCLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, pull_low = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, d;
    wire  [7:0] REG_RDATA;
    wire        MFP_IN, MFP_OUT, MFP_OE, HW_ENABLE, GPIN_OUT, GPIN_OE, MAIN_SINK_ENABLE, SECONDARY_SINK_ENABLE;
    wire        GPIN_IN = GPIN_OE ? GPIN_OUT : 1'b1;
    int         num_errors = 0, checked = 0, cycles = 0, seed = 32'hade9, mem [256];
    bit         pat_q [$];
    always #2.5 MCLK = ~MCLK;
    pgs_top #(.CNT0(CNT[0]), .CNT1(CNT[1]), .CNT2(CNT[2]), .CNT3(CNT[3])) uut (.MCLK(MCLK), .RST_N(RST_N),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .MFP_IN(MFP_IN), .MFP_OUT(MFP_OUT), .MFP_OE(MFP_OE), .HW_ENABLE(HW_ENABLE), .GPIN_IN(GPIN_IN),
        .GPIN_OUT(GPIN_OUT), .GPIN_OE(GPIN_OE), .MAIN_SINK_ENABLE(MAIN_SINK_ENABLE),
        .SECONDARY_SINK_ENABLE(SECONDARY_SINK_ENABLE));
    pgs_pin_model u_pin (.drv_out(MFP_OUT), .drv_oe(MFP_OE), .pull_low(pull_low), .pin_level(MFP_IN));
    // ------
    // Tasks
    // ------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        @(posedge MCLK);
        mem[a] = v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        @(posedge MCLK);
        v = REG_RDATA;
    endtask
    function automatic logic [7:0] exp_rd(input int a);
        // Input direction reads the pin, which idles high here
        if (a == 8'h81) return {6'h3F, (mem[a][0] ? mem[a][1] : 1'b1), mem[a][0]};
        if (a == 8'h80 || (a >= 8'h90 && a <= 8'h93)) return mem[a][7:0];
        return 8'h00;
    endfunction
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ------
    // Scenarios
    // ------
    initial begin
        foreach (mem[i]) mem[i] = 0;
        mem[8'h80] = 8'h01;
        mem[8'h81] = 8'hFC;
        repeat (6) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        for (int i = 0; i < 10; i++) begin
            rd((i < 2) ? 8'(8'h80 + i) : 8'(8'h8C + i), d);
            chk8(d, exp_rd((i < 2) ? 8'h80 + i : 8'h8C + i));
        end
        wr(8'h80, 8'h00);
        for (int i = 0; i < 4; i++) begin
            pull_low <= i[0];
            repeat (3) @(posedge MCLK);
            chk1(HW_ENABLE, !i[0]);
            chk1(MFP_OE, 1'b0);
        end
        repeat (8) begin
            wr(8'h81, 8'($random(seed)));
            @(posedge MCLK);
            chk1(MAIN_SINK_ENABLE, mem[8'h81][1]);
            chk1(GPIN_OUT, mem[8'h81][1]);
            chk1(SECONDARY_SINK_ENABLE, mem[8'h81][2]);
            chk1(GPIN_OE, mem[8'h81][0]);
            rd(8'h81, d);
            chk8(d, exp_rd(8'h81));
        end
        for (int v = 0; v < 2; v++) begin
            wr(8'h80, 8'(v * 4 + 1));
            repeat (2) @(posedge MCLK);
            chk1(MFP_OE, 1'b1);
            chk1(MFP_OUT, v[0]);
            wr(8'h80, 8'h03);
            pull_low <= v[0];
            repeat (3) @(posedge MCLK);
            rd(8'h80, d);
            chk1(d[2], !v[0]);
            chk1(MFP_OE, 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            wr(8'(8'h90 + b), 8'($random(seed)));
            rd(8'(8'h90 + b), d);
            chk8(d, exp_rd(8'h90 + b));
        end
        for (int k = 0; k < 32; k++) pat_q.push_back(mem[8'h90 + k / 8][k % 8]);
        for (int r = 0; r < 4; r++) begin
            for (int u = 1; u < 5; u++) begin
                wr(8'h80, 8'(r * 64 + u * 8 + 1));
                repeat (CNT[r] / 2 + 1) @(posedge MCLK);
                for (int s = 0; s < 64 * u; s++) begin
                    #1 chk1(MFP_OE, (s % (32 * u) < 32) ? pat_q[s % (32 * u)] : 1'b0);
                    repeat (CNT[r]) @(posedge MCLK);
                end
            end
        end
        end_of_test();
    end
endmodule // testbench
